// >>> verilog/sync_serial_pkg.sv
// shared constants for the synchronous serial port control and data window
package sync_serial_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] off_control_zero = 8'h00; // format, size, rate
   localparam logic [7:0] off_control_one = 8'h04; // serial_control_one
   localparam logic [7:0] off_data_window = 8'h08; // fifo_data_window
   localparam logic [7:0] off_status = 8'h0C; // fifo and busy flags
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int bit_loopback = 0; // loopback_select
   localparam int bit_enable = 1; // port_enable_bit
   localparam int bit_role = 2; // role_select
   localparam int bit_sod = 3; // slave_output_disable
   localparam int ctl1_width = 4; // bits 31:4 reserved
   localparam int size_lsb = 0; // word_size_field 3:0
   localparam int fmt_lsb = 4; // frame_format_field 5:4
   localparam int rate_lsb = 8; // half period count 15:8
   // ------------------------------------------------------------
   // reset values and sizes
   // ------------------------------------------------------------
   localparam logic [15:0] ctl0_reset = 16'h0000;
   localparam logic [3:0] ctl1_reset = 4'h0;
   localparam int data_width = 16; // significant bits per access
   localparam int fifo_depth = 8;
   localparam int ptr_width = 3;
   localparam logic [3:0] size_min_code = 4'h3; // below this is reserved
   localparam logic [4:0] min_bits = 5'h04; // used for reserved size codes
   localparam logic [4:0] cmd_bits = 5'h08; // command byte of half duplex
   localparam logic [4:0] full_bits = 5'h10; // sixteen bit word
   // ------------------------------------------------------------
   // frame formats
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      fmt_select = 2'h0, // select held low for the whole frame
      fmt_sync_pulse = 2'h1, // one high pulse before the frame
      fmt_half_duplex = 2'h2, // command byte out, response in
      fmt_reserved = 2'h3
   } frame_fmt_t;
   // status bit positions
   localparam int st_tfe = 0;
   localparam int st_tnf = 1;
   localparam int st_rne = 2;
   localparam int st_rff = 3;
   localparam int st_bsy = 4;
endpackage : sync_serial_pkg

// >>> verilog/sync_serial_ctrl_data.sv
// synchronous serial port: control registers, data window, fifos and shifter
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
module sync_serial_ctrl_data (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce, // low freezes every flop
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // serial pins
   input wire logic sclk_in, // peer clock in slave role
   input wire logic frame_in, // peer frame in slave role
   input wire logic serial_rx_pin,
   output logic sclk_out, // clock driven in master role
   output logic frame_out, // frame driven in master role
   output logic serial_tx_pin,
   output logic serial_tx_oe // high while the tx pin is driven
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [15:0] control_zero; // rate, format, word size
   logic [3:0] serial_control_one; // disable, role, enable, loopback
   logic [15:0] tx_mem [sync_serial_pkg::fifo_depth]; // transmit fifo
   logic [15:0] rx_mem [sync_serial_pkg::fifo_depth]; // receive fifo
   logic [3:0] tx_wr, tx_rd, rx_wr, rx_rd; // pointers with wrap bit
   logic tx_empty, tx_full, rx_empty, rx_full;
   logic st_idle_q; // engine idle, also read back by the status register
   logic bus_req, wr_data, rd_data, tx_pop, rx_push;
   logic [15:0] rx_word; // word finished by the shifter
   logic role, enable, loop_on, slave_output_disable;
   logic [1:0] fmt;
   logic [4:0] word_bits, frame_bits, tx_shift_amt;
   logic [15:0] word_mask;

   assign role = serial_control_one[sync_serial_pkg::bit_role];
   assign enable = serial_control_one[sync_serial_pkg::bit_enable];
   assign loop_on = serial_control_one[sync_serial_pkg::bit_loopback];
   assign slave_output_disable = serial_control_one[sync_serial_pkg::bit_sod];
   assign fmt = control_zero[sync_serial_pkg::fmt_lsb +: 2];
   // reserved size codes fall back to the shortest legal word
   assign word_bits = (control_zero[sync_serial_pkg::size_lsb +: 4] < sync_serial_pkg::size_min_code)
      ? sync_serial_pkg::min_bits
      : {1'b0, control_zero[sync_serial_pkg::size_lsb +: 4]} + 5'h01;
   // half duplex frames carry the command byte then the response word
   assign frame_bits = (fmt == sync_serial_pkg::fmt_half_duplex)
      ? sync_serial_pkg::cmd_bits + word_bits : word_bits;
   assign tx_shift_amt = (fmt == sync_serial_pkg::fmt_half_duplex)
      ? sync_serial_pkg::full_bits - sync_serial_pkg::cmd_bits
      : sync_serial_pkg::full_bits - word_bits;
   assign word_mask = 16'hFFFF >> (sync_serial_pkg::full_bits - word_bits);

   assign tx_empty = (tx_wr == tx_rd);
   assign tx_full = (tx_wr[2:0] == tx_rd[2:0]) && (tx_wr[3] != tx_rd[3]);
   assign rx_empty = (rx_wr == rx_rd);
   assign rx_full = (rx_wr[2:0] == rx_rd[2:0]) && (rx_wr[3] != rx_rd[3]);
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_data = bus_req && wb_we_i && (wb_adr_i == sync_serial_pkg::off_data_window);
   assign rd_data = bus_req && !wb_we_i && (wb_adr_i == sync_serial_pkg::off_data_window);

   // ------------------------------------------------------------
   // wishbone slave
   // ------------------------------------------------------------
   // ack comes one cycle after the request and drops the next cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
      end else if (ce) begin
         wb_ack_o <= bus_req;
      end
   end

   // control writes; lane 0 and 1 enables are honoured
   always_ff @(posedge clk) begin
      if (reset) begin
         control_zero <= sync_serial_pkg::ctl0_reset;
         serial_control_one <= sync_serial_pkg::ctl1_reset;
      end else if (ce && bus_req && wb_we_i) begin
         if (wb_adr_i == sync_serial_pkg::off_control_zero) begin
            if (wb_sel_i[0]) begin
               control_zero[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               control_zero[15:8] <= wb_dat_i[15:8];
            end
         end else if (wb_adr_i == sync_serial_pkg::off_control_one && wb_sel_i[0]) begin
            // reserved upper bits are not stored and read as zero
            serial_control_one <= wb_dat_i[sync_serial_pkg::ctl1_width-1:0];
         end
      end
   end

   // read data is registered alongside ack; unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (reset) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (ce && bus_req && !wb_we_i) begin
         unique case (wb_adr_i)
            sync_serial_pkg::off_control_zero: wb_dat_o <= {16'h0000, control_zero};
            sync_serial_pkg::off_control_one: wb_dat_o <= {28'h0000000, serial_control_one};
            // upper half is zero; empty fifo reads the stale slot
            sync_serial_pkg::off_data_window: wb_dat_o <= {16'h0000, rx_mem[rx_rd[2:0]]};
            sync_serial_pkg::off_status: wb_dat_o <= {27'h0000000,
               !st_idle_q || !tx_empty, rx_full, !rx_empty, !tx_full, tx_empty};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // fifos
   // ------------------------------------------------------------
   // no flush path from the enable bit: preloading stays legal
   always_ff @(posedge clk) begin
      if (reset) begin
         tx_wr <= 4'h0;
         tx_rd <= 4'h0;
      end else if (ce) begin
         if (wr_data && !tx_full) begin
            tx_mem[tx_wr[2:0]] <= wb_dat_i[15:0];
            tx_wr <= tx_wr + 4'h1;
         end
         if (tx_pop) begin
            tx_rd <= tx_rd + 4'h1;
         end
      end
   end

   // a push into a full receive fifo is dropped (overrun)
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_wr <= 4'h0;
         rx_rd <= 4'h0;
      end else if (ce) begin
         if (rx_push && !rx_full) begin
            rx_mem[rx_wr[2:0]] <= rx_word;
            rx_wr <= rx_wr + 4'h1;
         end
         if (rd_data && !rx_empty) begin
            rx_rd <= rx_rd + 4'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] pin_meta, pin_sync, pin_last; // {sclk, frame, rx}
   always_ff @(posedge clk) begin
      if (reset) begin
         // frame pin idles high: start there so reset shows no false edge
         pin_meta <= 3'h2;
         pin_sync <= 3'h2;
         pin_last <= 3'h2;
      end else if (ce) begin
         pin_meta <= {sclk_in, frame_in, serial_rx_pin};
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   // ------------------------------------------------------------
   // shift engine
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      st_idle = 3'b001, // waiting for data or a peer frame
      st_sync = 3'b010, // frame pulse before the first bit
      st_shift = 3'b100 // bits moving
   } shift_state_t;
   shift_state_t state;
   logic [7:0] half_cnt; // master half period counter
   logic [4:0] bit_cnt;
   logic [15:0] tx_shift, rx_shift;
   logic m_rise, m_fall, rise, fall, rx_bit, slave_start, master_start, half_done;

   assign st_idle_q = (state == st_idle);
   assign half_done = (half_cnt == control_zero[sync_serial_pkg::rate_lsb +: 8]);
   assign m_rise = half_done && !sclk_out && (state == st_shift);
   assign m_fall = half_done && sclk_out && (state == st_shift);
   assign rise = role ? (pin_sync[2] && !pin_last[2]) : m_rise;
   assign fall = role ? (!pin_sync[2] && pin_last[2]) : m_fall;
   // loopback takes the shifter output before the pin and its enable
   assign rx_bit = loop_on ? tx_shift[15] : pin_sync[0];
   // start only while enabled; the reserved format never starts
   assign master_start = enable && !role && !tx_empty && fmt != sync_serial_pkg::fmt_reserved;
   assign slave_start = enable && role && fmt != sync_serial_pkg::fmt_reserved
      && ((fmt == sync_serial_pkg::fmt_sync_pulse)
         ? (pin_sync[1] && !pin_last[1]) : (!pin_sync[1] && pin_last[1]));
   assign tx_pop = st_idle_q && (master_start || (slave_start && !tx_empty));
   assign rx_word = rx_shift & word_mask;

   // frame sequencing; dropping enable aborts the frame in flight
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= st_idle;
         bit_cnt <= 5'h00;
         rx_push <= 1'b0;
      end else if (ce) begin
         rx_push <= 1'b0;
         unique case (state)
            st_idle: begin
               bit_cnt <= 5'h00;
               if (master_start) begin
                  state <= (fmt == sync_serial_pkg::fmt_sync_pulse) ? st_sync : st_shift;
               end else if (slave_start) begin
                  state <= st_shift;
               end
            end
            st_sync: begin
               if (!enable) begin
                  state <= st_idle;
               end else if (half_done) begin
                  state <= st_shift;
               end
            end
            st_shift: begin
               if (!enable) begin
                  state <= st_idle;
               end else if (rise) begin
                  bit_cnt <= bit_cnt + 5'h01;
                  if (bit_cnt == frame_bits - 5'h01) begin
                     rx_push <= 1'b1;
                     state <= st_idle;
                  end
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   // shifters: tx moves on falling edges, rx samples on rising edges
   always_ff @(posedge clk) begin
      if (reset) begin
         tx_shift <= 16'h0000;
         rx_shift <= 16'h0000;
      end else if (ce) begin
         if (tx_pop) begin
            // align the word so its top significant bit leaves first
            tx_shift <= tx_mem[tx_rd[2:0]] << tx_shift_amt;
         end else if (st_idle_q && slave_start) begin
            tx_shift <= 16'h0000; // nothing queued: send zeros
         end else if (state == st_shift && fall) begin
            tx_shift <= {tx_shift[14:0], 1'b0};
         end
         if (state == st_shift && rise) begin
            rx_shift <= {rx_shift[14:0], rx_bit};
         end
      end
   end

   // master clock divider, runs only while a frame is active
   always_ff @(posedge clk) begin
      if (reset) begin
         half_cnt <= 8'h00;
         sclk_out <= 1'b0;
      end else if (ce) begin
         if (role || st_idle_q) begin
            half_cnt <= 8'h00;
            sclk_out <= 1'b0;
         end else if (half_done) begin
            half_cnt <= 8'h00;
            if (state == st_shift) begin
               sclk_out <= !sclk_out;
            end
         end else begin
            half_cnt <= half_cnt + 8'h01;
         end
      end
   end

   // frame and tx pin drivers; every output stays registered
   always_ff @(posedge clk) begin
      if (reset) begin
         frame_out <= 1'b1;
         serial_tx_pin <= 1'b0;
         serial_tx_oe <= 1'b0;
      end else if (ce) begin
         if (fmt == sync_serial_pkg::fmt_sync_pulse) begin
            frame_out <= !role && (state == st_sync || (st_idle_q && master_start));
         end else begin
            frame_out <= role || !((state != st_idle) || master_start);
         end
         serial_tx_pin <= (state == st_shift) ? tx_shift[15] : 1'b0;
         // master drives while enabled; slave only without output disable
         serial_tx_oe <= enable && (!role || !slave_output_disable);
      end
   end

endmodule : sync_serial_ctrl_data

// >>> verif/sync_serial_ctrl_data_checker.sv
// assertion checker for the serial port control and data window
`timescale 1ns/1ps
module sync_serial_ctrl_data_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic sclk_out,
   input wire logic serial_tx_pin,
   input wire logic serial_tx_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic [3:0] ctl; // shadow: sod, role, enable, loopback
   logic [3:0] age; // cycles since the last control write, saturating
   // ----------------------------------------
   // shadow of the control bits
   // ----------------------------------------
   // outputs are registered behind the control bits, so checks wait three cycles
   always_ff @(posedge clk) begin
      if (reset) begin
         ctl <= 4'h0;
         age <= 4'h0;
      end else if (ce && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                   && wb_adr_i == sync_serial_pkg::off_control_one) begin
         ctl <= wb_dat_i[3:0];
         age <= 4'h0;
      end else if (age != 4'hF) begin
         age <= age + 4'h1;
      end
   end
   wire logic settled = (age >= 4'h3); // control bits have reached the pins
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   property p_ack_answer;
      (wb_cyc_i && wb_stb_i && !wb_ack_o && ce) |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
   property p_ack_cause;
      $rose(wb_ack_o) |-> $past(wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_oe;
      settled |-> serial_tx_oe == (ctl[1] && (!ctl[2] || !ctl[3]));
   endproperty
   a_oe: assert property (p_oe) else $error("tx drive enable wrong");
   property p_idle;
      (settled && !ctl[1]) |-> !sclk_out && !serial_tx_pin;
   endproperty
   a_idle: assert property (p_idle) else $error("disabled port not idle");
   property p_slave_clk;
      (settled && ctl[2]) |-> !sclk_out ##1 !sclk_out;
   endproperty
   a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock");
   property p_ctl_read;
      (wb_ack_o && !wb_we_i && wb_adr_i == sync_serial_pkg::off_control_one)
         |-> wb_dat_o == {28'h0000000, ctl};
   endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
   property p_unmapped;
      (wb_ack_o && !wb_we_i && wb_adr_i > 8'h0C) |-> wb_dat_o == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   c_data_write: cover property (wb_ack_o && wb_we_i && wb_adr_i == 8'h08);
   c_frame: cover property ($rose(sclk_out));
   c_slave: cover property (settled && ctl[2] && ctl[1]);
endmodule : sync_serial_ctrl_data_checker
bind sync_serial_ctrl_data sync_serial_ctrl_data_checker u_checker (.clk(clk), .reset(reset),
   .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .sclk_out(sclk_out), .serial_tx_pin(serial_tx_pin), .serial_tx_oe(serial_tx_oe));

// >>> verif/serial_peer_model.sv
// serial peer that answers the port while it is master
`timescale 1ns/1ps
module serial_peer_model (
   input wire logic en,
   input wire logic [15:0] word,
   input wire logic sclk_out,
   input wire logic frame_out,
   input wire logic serial_tx_pin,
   output logic serial_rx_pin,
   output logic [15:0] captured,
   output int count
);
   logic [15:0] shreg = 16'h0000; // outgoing word, top bit on the line
   initial begin
      serial_rx_pin = 1'b0;
      captured = 16'h0000;
      count = 0;
   end
   // frame start: top bit stands before the first rising clock
   always @(negedge frame_out) begin
      if (en) begin
         shreg = word;
         serial_rx_pin = word[15];
         count = 0;
      end
   end
   // capture the port's bit on each rising clock, msb first
   always @(posedge sclk_out) begin
      if (en && !frame_out) begin
         captured = {captured[14:0], serial_tx_pin};
         count++;
      end
   end
   // next bit on the falling clock
   always @(negedge sclk_out) begin
      if (en && !frame_out) begin
         shreg = {shreg[14:0], ~shreg[0]};
         serial_rx_pin = shreg[15];
      end
   end
   // released line flips so a stale bit can never pass for data
   always @(posedge frame_out) serial_rx_pin = ~serial_rx_pin;
endmodule : serial_peer_model

// >>> verif/sync_serial_ctrl_data_bench.sv
// self-checking bench for the serial port control and data window
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module sync_serial_ctrl_data_bench;
   logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0;
   logic sclk_in = 0, frame_in = 1, rx_drv = 0, peer_en = 0, bench_rx = 0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] dat = 32'h0, q, w, wb_dat_o;
   logic [15:0] peer_word = 16'h0, peer_cap;
   logic wb_ack_o, sclk_out, frame_out, tx_pin, tx_oe, peer_rx;
   int err_total = 0, n_checks = 0, seed = 84, peer_cnt, bits, exp_q[$];
   wire logic rx_pin = bench_rx ? rx_drv : peer_rx; // bench drives in slave role
   always #2 clk = ~clk;
   sync_serial_ctrl_data u_dut (.clk(clk), .reset(reset), .ce(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sclk_in(sclk_in), .frame_in(frame_in),
      .serial_rx_pin(rx_pin), .sclk_out(sclk_out), .frame_out(frame_out),
      .serial_tx_pin(tx_pin), .serial_tx_oe(tx_oe));
   serial_peer_model u_peer (.en(peer_en), .word(peer_word), .sclk_out(sclk_out),
      .frame_out(frame_out), .serial_tx_pin(tx_pin), .serial_rx_pin(peer_rx),
      .captured(peer_cap), .count(peer_cnt));
   // ----------------------------------------
   // closing report
   // ----------------------------------------
   task print_verdict;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   // one classic bus cycle; read data lands in q at the ack edge
   task wb(input logic w_i, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w_i;
      adr <= a;
      dat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      cyc <= 0;
      stb <= 0;
      if (n >= 50) begin
         err_total++;
         print_verdict;
      end
   endtask : wb
   // poll a status bit until it reads v, bounded
   task wait_st(input int b, input logic v);
      int n;
      n = 0;
      do begin
         wb(0, sync_serial_pkg::off_status, 0);
         n++;
      end while (q[b] !== v && n < 500);
      if (n >= 500) begin
         err_total++;
         print_verdict;
      end
   endtask : wait_st
   initial begin
      repeat (5) @(posedge clk);
      reset <= 0;
      wb(0, sync_serial_pkg::off_control_one, 0); `CHK(q, 32'h0)
      wb(0, 8'h10, 0); `CHK(q, 32'h0)
      wb(1, sync_serial_pkg::off_control_one, 32'h8);
      wb(0, sync_serial_pkg::off_control_one, 0); `CHK(q, 32'h8)
      // loopback over word sizes 4, 8, 12, 16 and two formats, preloaded while off
      for (int i = 0; i < 4; i++) begin
         bits = 4 * i + 4;
         wb(1, sync_serial_pkg::off_control_one, 32'h1);
         wb(1, sync_serial_pkg::off_control_zero,
            {16'h0, 8'h07, 2'h0, 2'(i % 2), 4'(bits - 1)});
         repeat (3) begin
            w = $random(seed);
            exp_q.push_back(int'(w[15:0]) & ((1 << bits) - 1));
            wb(1, sync_serial_pkg::off_data_window, w);
         end
         `CHK(sclk_out, 1'b0)
         `CHK(frame_out, (i % 2) ? 1'b0 : 1'b1)
         wb(1, sync_serial_pkg::off_control_one, 32'h3);
         wait_st(sync_serial_pkg::st_bsy, 1'b0);
         repeat (3) begin
            wb(0, sync_serial_pkg::off_data_window, 0);
            w = 32'(exp_q.pop_front());
            `CHK(q[15:0], w[15:0])
         end
      end
      // master to the peer: plain frame, then half duplex command byte
      for (int i = 0; i < 2; i++) begin
         wb(1, sync_serial_pkg::off_control_one, i ? 32'h0 : 32'h1);
         wb(1, sync_serial_pkg::off_control_zero,
            {16'h0, 8'h07, 2'h0, (i ? 2'h2 : 2'h0), 4'h7});
         peer_word <= 16'($random(seed));
         peer_en <= 1;
         w = $random(seed);
         wb(1, sync_serial_pkg::off_data_window, w);
         wb(1, sync_serial_pkg::off_control_one, 32'h2);
         wait_st(sync_serial_pkg::st_bsy, 1'b0);
         `CHK(peer_cnt, i ? 16 : 8)
         `CHK(i ? peer_cap[15:8] : peer_cap[7:0], w[7:0])
         wb(0, sync_serial_pkg::off_data_window, 0);
         `CHK(q[15:0], {8'h0, i ? peer_word[7:0] : peer_word[15:8]})
      end
      // slave with output disabled; bench clocks in one byte at 48 ns
      peer_en <= 0;
      wb(1, sync_serial_pkg::off_control_one, 32'h0);
      wb(1, sync_serial_pkg::off_control_zero, {16'h0, 8'h07, 4'h0, 4'h7});
      wb(1, sync_serial_pkg::off_control_one, 32'hE);
      bench_rx <= 1;
      w = $random(seed);
      repeat (4) @(posedge clk);
      `CHK(tx_oe, 1'b0)
      // 48 ns link clock: six system clocks per half period
      frame_in <= 0;
      for (int b = 7; b >= 0; b--) begin
         rx_drv <= w[b];
         repeat (6) @(posedge clk);
         sclk_in <= 1;
         repeat (6) @(posedge clk);
         sclk_in <= 0;
      end
      repeat (6) @(posedge clk);
      frame_in <= 1;
      rx_drv <= ~w[0];
      wait_st(sync_serial_pkg::st_rne, 1'b1);
      wb(0, sync_serial_pkg::off_data_window, 0); `CHK(q[15:0], {8'h0, w[7:0]})
      wb(1, sync_serial_pkg::off_control_one, 32'hC);
      wb(1, sync_serial_pkg::off_control_one, 32'h6);
      repeat (4) @(posedge clk);
      `CHK(tx_oe, 1'b1)
      wb(1, sync_serial_pkg::off_control_one, 32'h4);
      wb(1, sync_serial_pkg::off_control_one, 32'hA);
      repeat (4) @(posedge clk);
      `CHK(tx_oe, 1'b1)
      print_verdict;
   end
endmodule : sync_serial_ctrl_data_bench
